//--- spp_port.sv
// Added by the designer: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - master data write starts clock and shifting
// - after a byte, clock stops, done flag sets
// - both shift registers form one ring
// - single-buffered transmit, double-buffered receive
// - enabled port forces input pin directions by role; outputs follow user choice
// - select low as master demotes to slave
// - select output is plain; input must stay high
// - slave active only while select is low
// - done flag interrupts when both enables set
// - no shifting while port is disabled; data write only loads shift register
// - order bit one sends lsb first
// - idle level bit sets resting clock level
// - rate bits divide clock by 4/16/64/128
// - done cleared by vector or status-then-data
// - data write during transfer sets collision
// - status-then-data clears collision and done
// - low six status bits read zero
// - data read gives buffer, write starts send
module spp_port
  import spp_pkg::*;
(
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // apb slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // system interrupt glue
  input wire logic global_irq_en_i,
  input wire logic irq_ack_i,
  output logic irq_o,
  // user pin direction choices
  input wire logic mosi_dir_out_i,
  input wire logic miso_dir_out_i,
  input wire logic sck_dir_out_i,
  input wire logic ss_dir_out_i,
  // serial pins
  input wire logic sck_i,
  input wire logic mosi_i,
  input wire logic miso_i,
  input wire logic ss_n_i,
  output spp_pins_t pins_o
);

  logic [7:0] ctrl_q; // control register
  logic done_q; // transfer done flag
  logic coll_q; // write collision flag
  logic armed_q; // status read saw a flag set
  logic [7:0] shift_q; // ring half
  logic [7:0] rxbuf_q; // receive buffer
  logic [3:0] edge_q; // clock edges done
  logic [6:0] div_q; // half period counter
  logic sck_prev_q; // last sampled slave clock
  logic in_q; // bit sampled on sampling edge
  spp_state_t state_q;
  logic [7:0] status_w;
  logic en_w, mst_w, lsb_w, clock_idle_level_w, clock_sample_phase_w;
  logic wr_acc, rd_acc, data_wr, data_acc, stat_rd;
  logic busy_w, demote_w, done_ev, half_tick;
  logic slv_lead, slv_trail, slv_act;
  logic [6:0] half_w;

  assign en_w = ctrl_q[SPP_EN_BIT];
  assign mst_w = ctrl_q[SPP_CTRL_BIT];
  assign lsb_w = ctrl_q[SPP_ORDER_BIT];
  assign clock_idle_level_w = ctrl_q[SPP_IDLE_BIT];
  assign clock_sample_phase_w = ctrl_q[SPP_PHASE_BIT];
  // apb access phase; every access completes in its first access cycle
  assign wr_acc = psel_i && penable_i && pwrite_i;
  assign rd_acc = psel_i && penable_i && !pwrite_i;
  assign data_acc = psel_i && penable_i && (paddr_i == SPP_ADDR_DATA);
  assign data_wr = wr_acc && (paddr_i == SPP_ADDR_DATA) && pstrb_i[0];
  assign stat_rd = rd_acc && (paddr_i == SPP_ADDR_STATUS);
  assign busy_w = (state_q != SPP_IDLE);
  // low six bits fixed at zero
  assign status_w = {done_q, coll_q, 6'h00};

  // demotion when select is an input and pulled low in master mode
  assign demote_w = en_w && mst_w && !ss_dir_out_i && !ss_n_i;

  // rate select, active only as master
  always_comb begin
    unique case (ctrl_q[1:0])
      2'b00: half_w = SPP_HALF_DIV4;
      2'b01: half_w = SPP_HALF_DIV16;
      2'b10: half_w = SPP_HALF_DIV64;
      default: half_w = SPP_HALF_DIV128;
    endcase
  end
  assign half_tick = (div_q == half_w - 7'h01);

  // slave clock edges, leading edge leaves the idle level
  assign slv_act = en_w && !mst_w && !ss_n_i;
  assign slv_lead = slv_act && (sck_i != sck_prev_q) && (sck_prev_q == clock_idle_level_w);
  assign slv_trail = slv_act && (sck_i != sck_prev_q) && (sck_prev_q != clock_idle_level_w);
  assign done_ev = busy_w && (edge_q == SPP_LAST_EDGE) &&
                   (state_q == SPP_MSHIFT ? half_tick : (slv_lead || slv_trail));

  // control register; demotion clears controller select
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl_q <= SPP_CONTROL_RESET;
    end else if (demote_w) begin
      ctrl_q[SPP_CTRL_BIT] <= 1'b0;
    end else if (wr_acc && paddr_i == SPP_ADDR_CONTROL && pstrb_i[0]) begin
      ctrl_q <= pwrite_i ? pwdata_i[7:0] : ctrl_q;
    end
  end

  // arming for the status-then-data clear
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      armed_q <= 1'b0;
    end else if (stat_rd) begin
      armed_q <= done_q || coll_q;
    end else if (data_acc) begin
      armed_q <= 1'b0;
    end
  end

  // done flag: set wins over every clear
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      done_q <= 1'b0;
    end else if (done_ev || demote_w) begin
      done_q <= 1'b1;
    end else if (irq_ack_i || (armed_q && data_acc)) begin
      done_q <= 1'b0;
    end
  end

  // collision flag
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      coll_q <= 1'b0;
    end else if (data_wr && busy_w) begin
      coll_q <= 1'b1;
    end else if (armed_q && coll_q && data_acc) begin
      coll_q <= 1'b0;
    end
  end

  // interrupt request
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= done_q && ctrl_q[SPP_IRQEN_BIT] && global_irq_en_i;
    end
  end

  // transfer engine: master clock generator and slave follower
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q <= SPP_IDLE;
      shift_q <= 8'h00;
      rxbuf_q <= 8'h00;
      edge_q <= SPP_EDGES;
      div_q <= 7'h00;
      in_q <= 1'b0;
    end else if (!en_w || demote_w) begin
      state_q <= SPP_IDLE;
      edge_q <= SPP_EDGES;
      div_q <= 7'h00;
      if (!en_w) begin
        shift_q <= data_wr ? pwdata_i[7:0] : shift_q;
      end
    end else begin
      unique case (state_q)
        SPP_IDLE: begin
          edge_q <= SPP_EDGES;
          div_q <= 7'h00;
          if (data_wr) begin
            shift_q <= pwdata_i[7:0];
            state_q <= mst_w ? SPP_MSHIFT : SPP_IDLE;
          end
          if (slv_act && !data_wr) begin
            state_q <= SPP_SSHIFT;
          end
        end
        SPP_MSHIFT: begin
          div_q <= half_tick ? 7'h00 : div_q + 7'h01;
          if (half_tick) begin
            edge_q <= edge_q + 4'h1;
            // sampling edge: leading when phase is zero
            if (edge_q[0] == clock_sample_phase_w) begin
              in_q <= miso_i;
            end else if (edge_q != SPP_EDGES) begin
              shift_q <= lsb_w ? {in_q, shift_q[7:1]} : {shift_q[6:0], in_q};
            end
            if (edge_q == SPP_LAST_EDGE) begin
              state_q <= SPP_IDLE;
              rxbuf_q <= clock_sample_phase_w ? (lsb_w ? {miso_i, shift_q[7:1]} : {shift_q[6:0], miso_i})
                                : (lsb_w ? {in_q, shift_q[7:1]} : {shift_q[6:0], in_q});
            end
          end
        end
        SPP_SSHIFT: begin
          if (!slv_act && edge_q == SPP_EDGES) begin
            state_q <= SPP_IDLE;
          end else if (slv_lead || slv_trail) begin
            edge_q <= edge_q + 4'h1;
            if (edge_q[0] == clock_sample_phase_w) begin
              in_q <= mosi_i;
            end else if (edge_q != SPP_EDGES) begin
              shift_q <= lsb_w ? {in_q, shift_q[7:1]} : {shift_q[6:0], in_q};
            end
            if (edge_q == SPP_LAST_EDGE) begin
              state_q <= SPP_IDLE;
              // receive buffer overwritten: an unread byte is lost
              rxbuf_q <= clock_sample_phase_w ? (lsb_w ? {mosi_i, shift_q[7:1]} : {shift_q[6:0], mosi_i})
                                : (lsb_w ? {in_q, shift_q[7:1]} : {shift_q[6:0], in_q});
            end
          end
        end
        default: state_q <= SPP_IDLE;
      endcase
    end
  end

  // slave clock history
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sck_prev_q <= 1'b0;
    end else begin
      sck_prev_q <= slv_act ? sck_i : clock_idle_level_w;
    end
  end

  // pins: outgoing bit is the end of the shift register selected by order
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pins_o <= '0;
    end else begin
      pins_o.mosi <= lsb_w ? shift_q[0] : shift_q[7];
      pins_o.miso <= lsb_w ? shift_q[0] : shift_q[7];
      // clock toggles each half period, rests at idle level
      pins_o.sck <= (state_q == SPP_MSHIFT) ? (clock_idle_level_w ^ edge_q[0]) : clock_idle_level_w;
      if (!en_w) begin
        pins_o.mosi_oe <= mosi_dir_out_i;
        pins_o.miso_oe <= miso_dir_out_i;
        pins_o.sck_oe <= sck_dir_out_i;
      end else if (mst_w && !demote_w) begin
        pins_o.mosi_oe <= mosi_dir_out_i;
        pins_o.miso_oe <= 1'b0;
        pins_o.sck_oe <= sck_dir_out_i;
      end else begin
        pins_o.mosi_oe <= 1'b0;
        pins_o.sck_oe <= 1'b0;
        pins_o.miso_oe <= miso_dir_out_i && !ss_n_i;
      end
    end
  end

  // apb read data, zero-wait answer, error on unmapped address
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prdata_o <= 32'h0000_0000;
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
    end else begin
      pready_o <= psel_i && !penable_i;
      pslverr_o <= psel_i && !penable_i && paddr_i != SPP_ADDR_CONTROL &&
                   paddr_i != SPP_ADDR_STATUS && paddr_i != SPP_ADDR_DATA;
      prdata_o <= 32'h0000_0000;
      if (psel_i && !penable_i && !pwrite_i) begin
        if (paddr_i == SPP_ADDR_CONTROL) prdata_o <= {24'h00_0000, ctrl_q};
        if (paddr_i == SPP_ADDR_STATUS) prdata_o <= {24'h00_0000, status_w};
        if (paddr_i == SPP_ADDR_DATA) prdata_o <= {24'h00_0000, rxbuf_q};
      end
    end
  end

  // checks
  a_rate_fast: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (state_q == SPP_MSHIFT && ctrl_q[1:0] == 2'b00 && div_q == 7'h00 && !demote_w && en_w)
    |=> (div_q == 7'h01)) else $error("divider step wrong");
  a_coll_set: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (data_wr && busy_w) |=> coll_q) else $error("collision not flagged");
  a_demote_ctl: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    demote_w |=> (!mst_w && done_q)) else $error("demotion incomplete");
  a_status_zero: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    status_w[5:0] == 6'h00) else $error("reserved bits nonzero");
  a_irq_gate: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    irq_o |-> $past(done_q && ctrl_q[SPP_IRQEN_BIT] && global_irq_en_i))
    else $error("stray interrupt");
  a_idle_sck: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (state_q == SPP_IDLE) [*2] |-> pins_o.sck == $past(clock_idle_level_w)) else $error("sck not idle");
  a_off_quiet: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    !en_w |=> state_q == SPP_IDLE) else $error("active while disabled");
  a_start_mst: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (en_w && mst_w && !demote_w && state_q == SPP_IDLE && data_wr)
    |=> state_q == SPP_MSHIFT) else $error("master did not start");
  a_miso_in: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (en_w && mst_w && !demote_w) |=> !pins_o.miso_oe) else $error("miso driven as master");
endmodule : spp_port
`default_nettype wire

//--- spp_pkg.sv
package spp_pkg;
  // register indices as printed; byte address is four times the index
  localparam logic [7:0] SPP_IDX_CONTROL = 8'h0d;
  localparam logic [7:0] SPP_IDX_STATUS = 8'h0e;
  localparam logic [7:0] SPP_IDX_DATA = 8'h0f;
  localparam logic [11:0] SPP_ADDR_CONTROL = 12'h034;
  localparam logic [11:0] SPP_ADDR_STATUS = 12'h038;
  localparam logic [11:0] SPP_ADDR_DATA = 12'h03c;
  // control field positions
  localparam int SPP_IRQEN_BIT = 7;
  localparam int SPP_EN_BIT = 6;
  localparam int SPP_ORDER_BIT = 5;
  localparam int SPP_CTRL_BIT = 4;
  localparam int SPP_IDLE_BIT = 3;
  localparam int SPP_PHASE_BIT = 2;
  // status field positions
  localparam int SPP_DONE_BIT = 7;
  localparam int SPP_COLL_BIT = 6;
  localparam logic [7:0] SPP_CONTROL_RESET = 8'h04;
  // half-period counts of the four rates (divide by 4, 16, 64, 128)
  localparam logic [6:0] SPP_HALF_DIV4 = 7'h02;
  localparam logic [6:0] SPP_HALF_DIV16 = 7'h08;
  localparam logic [6:0] SPP_HALF_DIV64 = 7'h20;
  localparam logic [6:0] SPP_HALF_DIV128 = 7'h40;
  localparam logic [3:0] SPP_EDGES = 4'h0;
  localparam logic [3:0] SPP_LAST_EDGE = 4'hf;

  typedef enum logic [1:0] {
    SPP_IDLE = 2'b00,
    SPP_MSHIFT = 2'b01,
    SPP_SSHIFT = 2'b10
  } spp_state_t;

  // pin outputs and their enables
  typedef struct packed {
    logic sck;
    logic sck_oe;
    logic mosi;
    logic mosi_oe;
    logic miso;
    logic miso_oe;
  } spp_pins_t;
endpackage : spp_pkg

//--- spp_slave_model.sv
`timescale 1ns/1ps
`default_nettype none
// remote slave: its 8-bit shift register closes the ring with the port
module spp_slave_model (
  // serial side
  input wire logic sck_i,
  input wire logic mosi_i,
  input wire logic sel_n_i,
  output logic miso_o,
  // mode and bytes
  input wire logic idle_i,
  input wire logic phase_i,
  input wire logic lsb_i,
  input wire logic [7:0] tx_i,
  output logic [7:0] rx_o
);
  logic [7:0] sr_q = 8'h00; // reply shift register
  logic skip_q = 1'h0; // phase one: first leading edge only presents a bit
  logic last_q = 1'h0; // last bit shown before release
  // reply byte loads on select; single buffered, held for the whole byte
  always @(negedge sel_n_i) begin
    sr_q = tx_i;
    skip_q = phase_i;
  end
  always @(posedge sel_n_i) last_q = lsb_i ? sr_q[0] : sr_q[7];
  // sample on one edge kind, shift on the other
  always @(sck_i) begin
    if (!sel_n_i && ((sck_i != idle_i) ^ phase_i)) begin
      rx_o = lsb_i ? {mosi_i, rx_o[7:1]} : {rx_o[6:0], mosi_i};
    end else if (!sel_n_i && skip_q) begin
      skip_q = 1'h0;
    end else if (!sel_n_i) begin
      sr_q = lsb_i ? sr_q >> 1 : sr_q << 1;
    end
  end
  // a released line shows the inverse, never a stale value
  assign miso_o = sel_n_i ? ~last_q : (lsb_i ? sr_q[0] : sr_q[7]);
endmodule : spp_slave_model
`default_nettype wire

//--- spp_port_tb.sv
`timescale 1ns/1ps
`default_nettype none
module spp_port_tb;
  import spp_pkg::*;
  // clock, reset and apb
  logic mclk_i = 1'h0;
  logic rst_n_i = 1'h0;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  // interrupt glue and select
  logic gie = 1'h1;
  logic ack = 1'h0;
  logic irq;
  logic ss_dir = 1'h1;
  logic ss_n = 1'h1;
  spp_pins_t pins;
  // current mode and peer bytes
  logic [7:0] ctrl = 8'h00;
  logic [7:0] stx = 8'h00;
  logic [7:0] srx;
  logic miso_m;
  // wire levels from all drivers; undriven sck rests at the idle level, undriven mosi reads low
  wire logic sck_w = pins.sck_oe ? pins.sck : ctrl[SPP_IDLE_BIT];
  wire logic mosi_w = pins.mosi_oe ? pins.mosi : 1'h0;
  wire logic miso_w = pins.miso_oe ? pins.miso : miso_m;
  int fails = 0;
  int tests_run = 0;
  int edges = 0;
  int act = 0;
  logic [31:0] rdv;
  logic err;

  initial forever #2.5 mclk_i = ~mclk_i;
  // count serial clock toggles and cycles spent off the idle level
  always @(sck_w) edges++;
  always @(posedge mclk_i) if (sck_w !== ctrl[SPP_IDLE_BIT]) act++;

  spp_port uut (
    .mclk_i(mclk_i), .rst_n_i(rst_n_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(4'hf),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .global_irq_en_i(gie), .irq_ack_i(ack), .irq_o(irq),
    .mosi_dir_out_i(1'h1), .miso_dir_out_i(1'h1), .sck_dir_out_i(1'h1),
    .ss_dir_out_i(ss_dir), .sck_i(sck_w), .mosi_i(mosi_w), .miso_i(miso_w),
    .ss_n_i(ss_n), .pins_o(pins)
  );
  spp_slave_model peer (
    .sck_i(sck_w), .mosi_i(mosi_w), .sel_n_i(ss_n), .miso_o(miso_m),
    .idle_i(ctrl[SPP_IDLE_BIT]), .phase_i(ctrl[SPP_PHASE_BIT]),
    .lsb_i(ctrl[SPP_ORDER_BIT]), .tx_i(stx), .rx_o(srx)
  );

  task results;
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : results

  task chk(input string what, input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // one apb transfer; request held until pready is seen high
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk_i);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk_i);
    penable <= 1'h1;
    do begin
      @(posedge mclk_i);
      n++;
    end while (pready !== 1'h1 && n < 64);
    rdv = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    if (n >= 64) begin
      fails++;
      results();
    end
  endtask : apb

  task wr(input logic [11:0] a, input logic [7:0] d);
    apb(1'h1, a, {24'h00_0000, d});
  endtask : wr

  task rd(input string what, input logic [11:0] a, input logic [7:0] exp);
    apb(1'h0, a, 32'h0000_0000);
    chk(what, rdv, {24'h00_0000, exp});
  endtask : rd

  // one master byte; optional second write while shifting
  task xfer(input logic [7:0] c, input logic [7:0] tx, input logic [7:0] rx,
            input logic coll);
    int n;
    logic [6:0] half;
    n = 0;
    half = c[1] ? (c[0] ? SPP_HALF_DIV128 : SPP_HALF_DIV64)
                : (c[0] ? SPP_HALF_DIV16 : SPP_HALF_DIV4);
    ctrl = c;
    stx = rx;
    wr(SPP_ADDR_CONTROL, c);
    // let the new idle level reach the pin before selecting the peer
    repeat (2) @(posedge mclk_i);
    ss_n <= 1'h0;
    @(posedge mclk_i);
    edges = 0;
    act = 0;
    wr(SPP_ADDR_DATA, tx);
    if (coll) begin
      rd("status busy", SPP_ADDR_STATUS, 8'h00);
      wr(SPP_ADDR_DATA, 8'hff);
      rd("status collision", SPP_ADDR_STATUS, 8'h40);
    end
    do begin
      apb(1'h0, SPP_ADDR_STATUS, 32'h0000_0000);
      n++;
    end while (rdv[SPP_DONE_BIT] !== 1'h1 && n < 1000);
    if (n >= 1000) begin
      fails++;
      results();
    end
    chk("status done", rdv, {24'h00_0000, 1'h1, coll, 6'h00});
    chk("irq", irq, c[7]);
    chk("sck edges", edges, 16);
    chk("sck active", act, 8 * half);
    chk("sck idle", sck_w, c[SPP_IDLE_BIT]);
    rd("rx data", SPP_ADDR_DATA, rx);
    rd("status clear", SPP_ADDR_STATUS, 8'h00);
    chk("irq clear", irq, 1'h0);
    chk("peer rx", srx, tx);
    rd("control kept", SPP_ADDR_CONTROL, c);
    ss_n <= 1'h1;
  endtask : xfer

  initial begin
    repeat (8) @(posedge mclk_i);
    rst_n_i <= 1'h1;
    rd("control reset", SPP_ADDR_CONTROL, 8'h04);
    rd("status reset", SPP_ADDR_STATUS, 8'h00);
    apb(1'h0, 12'h040, 32'h0000_0000);
    chk("unmapped error", err, 1'h1);
    $display("test reset done");
    // disabled port must not shift
    ctrl = 8'h10;
    wr(SPP_ADDR_CONTROL, 8'h10);
    edges = 0;
    wr(SPP_ADDR_DATA, 8'h55);
    repeat (64) @(posedge mclk_i);
    chk("idle edges", edges, 0);
    rd("idle status", SPP_ADDR_STATUS, 8'h00);
    $display("test disabled done");
    // all four modes and rates, non-symmetric sent bytes
    xfer(8'hd0, 8'ha6, 8'h3c, 1'h0);
    xfer(8'h7d, 8'h83, 8'h7e, 1'h0);
    xfer(8'h56, 8'h12, 8'hf0, 1'h0);
    xfer(8'h7b, 8'hc4, 8'h5a, 1'h1);
    $display("test transfers done");
    // select input pulled low while master
    ss_dir <= 1'h0;
    ctrl = 8'hd0;
    wr(SPP_ADDR_CONTROL, 8'hd0);
    gie <= 1'h0;
    ss_n <= 1'h0;
    rd("demoted control", SPP_ADDR_CONTROL, 8'hc0);
    rd("demoted status", SPP_ADDR_STATUS, 8'h80);
    chk("masked irq", irq, 1'h0);
    chk("sck released", pins.sck_oe, 1'h0);
    chk("mosi released", pins.mosi_oe, 1'h0);
    chk("miso driven", pins.miso_oe, 1'h1);
    gie <= 1'h1;
    repeat (2) @(posedge mclk_i);
    chk("irq raised", irq, 1'h1);
    ack <= 1'h1;
    @(posedge mclk_i);
    ack <= 1'h0;
    rd("vector clear", SPP_ADDR_STATUS, 8'h00);
    ss_n <= 1'h1;
    repeat (2) @(posedge mclk_i);
    chk("miso passive", pins.miso_oe, 1'h0);
    ss_dir <= 1'h1;
    wr(SPP_ADDR_CONTROL, 8'h50);
    rd("master again", SPP_ADDR_CONTROL, 8'h50);
    $display("test demotion done");
    results();
  end
endmodule : spp_port_tb
`default_nettype wire
